// File: include/msg_pkg.sv
// Message codes, negotiation limits and state encodings shared by both link ends.
package msg_pkg;

	// Message codes carried on the link.
	localparam logic [7:0] MSG_CMD_COMPLETE = 8'h00;
	localparam logic [7:0] MSG_EXTENDED = 8'h01;
	localparam logic [7:0] MSG_SAVE_PTR = 8'h02;
	localparam logic [7:0] MSG_RESTORE_PTR = 8'h03;
	localparam logic [7:0] MSG_DISCONNECT = 8'h04;
	localparam logic [7:0] MSG_INIT_ERROR = 8'h05;
	localparam logic [7:0] MSG_ABORT = 8'h06;
	localparam logic [7:0] MSG_REJECT = 8'h07;
	localparam logic [7:0] MSG_NOP = 8'h08;
	localparam logic [7:0] MSG_PARITY_ERROR = 8'h09;
	localparam logic [7:0] MSG_LINKED_DONE = 8'h0a;
	localparam logic [7:0] MSG_LINKED_FLAG = 8'h0b;
	localparam logic [7:0] MSG_DEVICE_RESET = 8'h0c;
	localparam logic [7:0] MSG_ABORT_TAG = 8'h0d;
	localparam logic [7:0] MSG_CLEAR_QUEUE = 8'h0e;
	localparam logic [7:0] MSG_TAG_SIMPLE = 8'h20;
	localparam logic [7:0] MSG_TAG_HEAD = 8'h21;
	localparam logic [7:0] MSG_TAG_ORDERED = 8'h22;
	localparam int IDENTIFY_BIT = 7;

	// Synchronous transfer request layout.
	localparam logic [7:0] SYNC_LEN = 8'h03;
	localparam logic [7:0] SYNC_CODE = 8'h01;
	localparam logic [2:0] SYNC_BYTES = 3'h5;
	localparam logic [2:0] SYNC_PERIOD_IDX = 3'h3;
	localparam logic [2:0] SYNC_OFFSET_IDX = 3'h4;

	// Period factor limits and offset ceiling.
	localparam logic [7:0] FACTOR_LVD_MIN = 8'h0a;
	localparam logic [7:0] FACTOR_SE_MIN = 8'h0c;
	localparam logic [7:0] FACTOR_MAX = 8'h6a;
	localparam logic [7:0] OFFSET_MAX = 8'h3f;
	localparam int FACTOR_NS = 4;
	localparam int PERIOD_STEP_NS = 25;

	// Reset value of a stored agreement: factor zero, offset zero, asynchronous.
	localparam logic [13:0] AGREE_RESET = 14'h0000;

	typedef enum logic [2:0] {
		T_IDLE = 3'h0,
		T_EXT_LEN = 3'h1,
		T_EXT_CODE = 3'h2,
		T_EXT_PERIOD = 3'h3,
		T_EXT_OFFSET = 3'h4,
		T_TAG = 3'h5,
		T_SEND = 3'h6
	} tgt_state_e;

	typedef enum logic [0:0] {
		I_IDLE = 1'h0,
		I_SEND = 1'h1
	} ini_state_e;

	// Period in ns from a factor, rounded up to the next 25 ns step.
	function automatic logic [10:0] period_ns(input logic [7:0] f);
		logic [10:0] raw;
		raw = 11'(f) * 11'(FACTOR_NS) + 11'(PERIOD_STEP_NS - 1);
		// The fastest low-voltage factor stands for a single 25 ns step, not for four times the factor.
		if (f == FACTOR_LVD_MIN) begin
			raw = 11'(PERIOD_STEP_NS);
		end
		return 11'((raw / 11'(PERIOD_STEP_NS)) * 11'(PERIOD_STEP_NS));
	endfunction

endpackage

// File: include/msg_link_if.sv
// Byte-level message link between the target end and the initiator end.
`timescale 1ns/1ps
interface msg_link_if;
	logic mo_valid;
	logic [7:0] mo_data;
	logic mo_atn;
	logic mo_ready;
	logic mi_valid;
	logic [7:0] mi_data;
	logic mi_ready;
	logic bus_free;
	logic bus_reset;
	logic [3:0] initiator_id;

	modport target (
		input mo_valid, mo_data, mo_atn, mi_ready, bus_reset, initiator_id,
		output mo_ready, mi_valid, mi_data, bus_free
	);

	modport initiator (
		output mo_valid, mo_data, mo_atn, mi_ready, bus_reset, initiator_id,
		input mo_ready, mi_valid, mi_data, bus_free
	);
endinterface

// File: hdl/msg_initiator.sv
// Initiator end of the message link: sends out messages and tracks the sync agreement.
`timescale 1ns/1ps
module msg_initiator (
	input wire logic ref_clk,
	input wire logic reset_n,
	msg_link_if.initiator lnk,
	input wire logic [3:0] my_id,
	input wire logic hard_reset_req,
	input wire logic sdtr_req,
	input wire logic [7:0] sdtr_period,
	input wire logic [7:0] sdtr_offset,
	input wire logic tag_req,
	input wire logic [7:0] tag_type,
	input wire logic [7:0] tag_value,
	input wire logic msg_req,
	input wire logic [7:0] msg_code,
	output logic req_taken,
	output logic sdtr_refused,
	output logic neg_done,
	output logic need_negotiation,
	output logic [7:0] agreed_period,
	output logic [7:0] agreed_offset,
	output logic [10:0] agreed_period_ns,
	output logic sync_mode,
	output logic in_valid,
	output logic [7:0] in_code,
	output logic [7:0] in_tag,
	output logic bus_free_seen
);

	typedef struct packed {
		msg_pkg::ini_state_e st;
		logic [4:0][7:0] txb;
		logic [2:0] cnt;
		logic [2:0] idx;
		logic mo_valid;
		logic [7:0] mo_data;
		logic mo_atn;
		logic mi_ready;
		logic bus_reset;
		logic [3:0] id;
		logic identified;
		logic [2:0] rx_idx;
		logic rx_ext;
		logic [7:0] rx_period;
		logic taken;
		logic refused;
		logic done;
		logic need_neg;
		logic [7:0] period;
		logic [7:0] offset;
		logic [10:0] period_ns;
		logic sync;
		logic in_valid;
		logic [7:0] in_code;
		logic [7:0] in_tag;
		logic free_seen;
	} ini_s;

	ini_s s_r;
	ini_s s_nxt;
	logic took;
	logic got;

	assign took = s_r.mo_valid && lnk.mo_ready;
	assign got = lnk.mi_valid && s_r.mi_ready;

	// Next state: request launch, byte pacing, inbound parsing.
	always_comb begin
		logic load;
		logic [4:0][7:0] lbuf;
		logic [2:0] lcnt;
		load = 1'b0;
		lbuf = '0;
		lcnt = 3'h1;
		s_nxt = s_r;
		s_nxt.taken = 1'b0;
		s_nxt.refused = 1'b0;
		s_nxt.done = 1'b0;
		s_nxt.in_valid = 1'b0;
		s_nxt.free_seen = 1'b0;
		s_nxt.bus_reset = 1'b0;
		s_nxt.id = my_id;
		s_nxt.mi_ready = 1'b1;
		// Launch a request only when no message is in flight.
		if (s_r.st == msg_pkg::I_IDLE) begin
			if (hard_reset_req) begin
				s_nxt.bus_reset = 1'b1;
				s_nxt.taken = 1'b1;
				s_nxt.identified = 1'b0;
				s_nxt.period = '0;
				s_nxt.offset = '0;
				s_nxt.need_neg = 1'b1;
			end else if (sdtr_req) begin
				s_nxt.taken = 1'b1;
				if (s_r.identified) begin
					load = 1'b1;
					lbuf = {sdtr_offset, sdtr_period, msg_pkg::SYNC_CODE, msg_pkg::SYNC_LEN,
						msg_pkg::MSG_EXTENDED};
					lcnt = msg_pkg::SYNC_BYTES;
				end else begin
					s_nxt.refused = 1'b1;
				end
			end else if (tag_req) begin
				load = 1'b1;
				s_nxt.taken = 1'b1;
				lbuf = {24'h000000, tag_value, tag_type};
				lcnt = 3'h2;
			end else if (msg_req) begin
				load = 1'b1;
				s_nxt.taken = 1'b1;
				lbuf = {32'h00000000, msg_code};
				if (msg_code[msg_pkg::IDENTIFY_BIT]) begin
					s_nxt.identified = 1'b1;
				end
				if (msg_code == msg_pkg::MSG_DEVICE_RESET) begin
					s_nxt.period = '0;
					s_nxt.offset = '0;
					s_nxt.need_neg = 1'b1;
				end
			end
		end
		if (load) begin
			s_nxt.st = msg_pkg::I_SEND;
			s_nxt.txb = lbuf;
			s_nxt.cnt = lcnt;
			s_nxt.idx = 3'h0;
			s_nxt.mo_valid = 1'b1;
			s_nxt.mo_data = lbuf[0];
			s_nxt.mo_atn = (lcnt != 3'h1);
		end
		// Step through the outbound bytes; ATN drops on the final one.
		if (s_r.st == msg_pkg::I_SEND && took) begin
			if (s_r.idx + 3'h1 == s_r.cnt) begin
				s_nxt.st = msg_pkg::I_IDLE;
				s_nxt.mo_valid = 1'b0;
				s_nxt.mo_atn = 1'b0;
			end else begin
				s_nxt.idx = s_r.idx + 3'h1;
				s_nxt.mo_data = s_r.txb[s_r.idx + 3'h1];
				s_nxt.mo_atn = (s_r.idx + 3'h2 != s_r.cnt);
			end
		end
		// Parse inbound bytes: single codes, simple tag pairs and the sync answer.
		if (got) begin
			s_nxt.rx_idx = s_r.rx_idx + 3'h1;
			if (s_r.rx_idx == 3'h0) begin
				s_nxt.rx_ext = (lnk.mi_data == msg_pkg::MSG_EXTENDED);
				if (lnk.mi_data != msg_pkg::MSG_EXTENDED && lnk.mi_data != msg_pkg::MSG_TAG_SIMPLE) begin
					s_nxt.in_valid = 1'b1;
					s_nxt.in_code = lnk.mi_data;
					s_nxt.rx_idx = 3'h0;
				end
			end else if (!s_r.rx_ext) begin
				s_nxt.in_valid = 1'b1;
				s_nxt.in_code = msg_pkg::MSG_TAG_SIMPLE;
				s_nxt.in_tag = lnk.mi_data;
				s_nxt.rx_idx = 3'h0;
			end else if (s_r.rx_idx == msg_pkg::SYNC_PERIOD_IDX) begin
				s_nxt.rx_period = lnk.mi_data;
			end else if (s_r.rx_idx == msg_pkg::SYNC_OFFSET_IDX) begin
				s_nxt.period = s_r.rx_period;
				s_nxt.offset = lnk.mi_data;
				s_nxt.done = 1'b1;
				s_nxt.need_neg = 1'b0;
				s_nxt.rx_idx = 3'h0;
			end
		end
		// A bus free ends the connection and any partial message.
		if (lnk.bus_free) begin
			s_nxt.free_seen = 1'b1;
			s_nxt.identified = 1'b0;
			s_nxt.rx_idx = 3'h0;
			s_nxt.st = msg_pkg::I_IDLE;
			s_nxt.mo_valid = 1'b0;
			s_nxt.mo_atn = 1'b0;
		end
		s_nxt.sync = (s_nxt.offset != 8'h00);
		s_nxt.period_ns = msg_pkg::period_ns(s_nxt.period);
	end

	// State register; power-on reset forces renegotiation.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.need_neg <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lnk.mo_valid = s_r.mo_valid;
	assign lnk.mo_data = s_r.mo_data;
	assign lnk.mo_atn = s_r.mo_atn;
	assign lnk.mi_ready = s_r.mi_ready;
	assign lnk.bus_reset = s_r.bus_reset;
	assign lnk.initiator_id = s_r.id;
	assign req_taken = s_r.taken;
	assign sdtr_refused = s_r.refused;
	assign neg_done = s_r.done;
	assign need_negotiation = s_r.need_neg;
	assign agreed_period = s_r.period;
	assign agreed_offset = s_r.offset;
	assign agreed_period_ns = s_r.period_ns;
	assign sync_mode = s_r.sync;
	assign in_valid = s_r.in_valid;
	assign in_code = s_r.in_code;
	assign in_tag = s_r.in_tag;
	assign bus_free_seen = s_r.free_seen;

endmodule

// File: hdl/msg_target.sv
// Target end of the message link: decodes messages, rejects unknown ones, negotiates sync terms.
`timescale 1ns/1ps
module msg_target #(
	parameter int IDS = 16
) (
	input wire logic ref_clk,
	input wire logic reset_n,
	msg_link_if.target lnk,
	input wire logic lvd_mode,
	input wire logic nexus_valid,
	input wire logic tx_req,
	input wire logic [7:0] tx_code,
	input wire logic tx_tag_req,
	input wire logic [7:0] tx_tag,
	output logic tx_taken,
	output logic rx_valid,
	output logic [7:0] rx_code,
	output logic tag_valid,
	output logic [7:0] tag_type,
	output logic [7:0] tag_value,
	output logic device_reset,
	output logic [7:0] agreed_period,
	output logic [7:0] agreed_offset,
	output logic [10:0] agreed_period_ns,
	output logic sync_mode
);

	typedef struct packed {
		msg_pkg::tgt_state_e st;
		logic [7:0] req_period;
		logic [7:0] tag_kind;
		logic [4:0][7:0] txb;
		logic [2:0] cnt;
		logic [2:0] idx;
		logic free_after;
		logic [IDS-1:0][13:0] agree;
		logic mo_ready;
		logic mi_valid;
		logic [7:0] mi_data;
		logic bus_free;
		logic taken;
		logic rx_valid;
		logic [7:0] rx_code;
		logic tag_valid;
		logic [7:0] tag_type;
		logic [7:0] tag_value;
		logic dev_reset;
		logic [7:0] period;
		logic [7:0] offset;
		logic [10:0] period_ns;
		logic sync;
	} tgt_s;

	tgt_s s_r;
	tgt_s s_nxt;
	logic take;
	logic sent;

	assign take = lnk.mo_valid && s_r.mo_ready;
	assign sent = s_r.mi_valid && lnk.mi_ready;

	// Answer factor and asynchronous flag for a requested factor.
	function automatic logic [8:0] map_period(input logic [7:0] m, input logic lvd);
		logic [7:0] floor_f;
		floor_f = lvd ? msg_pkg::FACTOR_LVD_MIN : msg_pkg::FACTOR_SE_MIN;
		if (m < floor_f) begin
			map_period = {floor_f, 1'b1};
		end else if (m == msg_pkg::FACTOR_LVD_MIN) begin
			map_period = {m, 1'b0};
		end else if (m < msg_pkg::FACTOR_SE_MIN) begin
			map_period = {msg_pkg::FACTOR_SE_MIN, 1'b0};
		end else if (m > msg_pkg::FACTOR_MAX) begin
			map_period = {msg_pkg::FACTOR_MAX, 1'b1};
		end else begin
			map_period = {m, 1'b0};
		end
	endfunction

	// True for codes that only ever travel from target to initiator.
	function automatic logic in_only(input logic [7:0] c);
		in_only = (c == msg_pkg::MSG_CMD_COMPLETE) || (c == msg_pkg::MSG_SAVE_PTR) ||
			(c == msg_pkg::MSG_RESTORE_PTR) || (c == msg_pkg::MSG_DISCONNECT) ||
			(c == msg_pkg::MSG_LINKED_DONE) || (c == msg_pkg::MSG_LINKED_FLAG);
	endfunction

	// Next state: inbound decode, negotiation answer, outbound byte pacing.
	always_comb begin
		logic load;
		logic reject;
		logic drop;
		logic [4:0][7:0] lbuf;
		logic [2:0] lcnt;
		logic lfree;
		logic [8:0] ans;
		logic [7:0] off;
		load = 1'b0;
		reject = 1'b0;
		drop = 1'b0;
		lbuf = '0;
		lcnt = 3'h1;
		lfree = 1'b0;
		ans = map_period(s_r.req_period, lvd_mode);
		off = (lnk.mo_data > msg_pkg::OFFSET_MAX) ? msg_pkg::OFFSET_MAX : lnk.mo_data;
		s_nxt = s_r;
		s_nxt.bus_free = 1'b0;
		s_nxt.taken = 1'b0;
		s_nxt.rx_valid = 1'b0;
		s_nxt.tag_valid = 1'b0;
		s_nxt.dev_reset = 1'b0;
		unique case (s_r.st)
			msg_pkg::T_IDLE: begin
				if (take) begin
					if (lnk.mo_data == msg_pkg::MSG_EXTENDED) begin
						s_nxt.st = msg_pkg::T_EXT_LEN;
						drop = !lnk.mo_atn;
					end else if (lnk.mo_data == msg_pkg::MSG_TAG_SIMPLE || lnk.mo_data == msg_pkg::MSG_TAG_HEAD ||
						lnk.mo_data == msg_pkg::MSG_TAG_ORDERED) begin
						s_nxt.st = msg_pkg::T_TAG;
						s_nxt.tag_kind = lnk.mo_data;
					end else if (lnk.mo_data == msg_pkg::MSG_DEVICE_RESET) begin
						s_nxt.agree = {IDS{msg_pkg::AGREE_RESET}};
						s_nxt.dev_reset = 1'b1;
						s_nxt.bus_free = 1'b1;
					end else if (lnk.mo_data[msg_pkg::IDENTIFY_BIT] || (lnk.mo_data >= msg_pkg::MSG_INIT_ERROR &&
						lnk.mo_data <= msg_pkg::MSG_CLEAR_QUEUE && !in_only(lnk.mo_data))) begin
						s_nxt.rx_valid = 1'b1;
						s_nxt.rx_code = lnk.mo_data;
					end else begin
						reject = 1'b1;
					end
				end else if (tx_tag_req) begin
					load = 1'b1;
					s_nxt.taken = 1'b1;
					lbuf = {24'h000000, tx_tag, msg_pkg::MSG_TAG_SIMPLE};
					lcnt = 3'h2;
				end else if (tx_req && in_only(tx_code)) begin
					load = 1'b1;
					s_nxt.taken = 1'b1;
					lbuf = {32'h00000000, tx_code};
					lfree = (tx_code == msg_pkg::MSG_CMD_COMPLETE);
				end
			end
			msg_pkg::T_EXT_LEN: begin
				if (take) begin
					s_nxt.st = msg_pkg::T_EXT_CODE;
					reject = (lnk.mo_data != msg_pkg::SYNC_LEN);
					drop = !reject && !lnk.mo_atn;
				end
			end
			msg_pkg::T_EXT_CODE: begin
				if (take) begin
					s_nxt.st = msg_pkg::T_EXT_PERIOD;
					reject = (lnk.mo_data != msg_pkg::SYNC_CODE);
					drop = !reject && !lnk.mo_atn;
				end
			end
			msg_pkg::T_EXT_PERIOD: begin
				if (take) begin
					s_nxt.st = msg_pkg::T_EXT_OFFSET;
					s_nxt.req_period = lnk.mo_data;
					drop = !lnk.mo_atn;
				end
			end
			msg_pkg::T_EXT_OFFSET: begin
				if (take) begin
					if (ans[0]) begin
						off = 8'h00;
					end
					s_nxt.agree[lnk.initiator_id] = {ans[8:1], off[5:0]};
					load = 1'b1;
					lbuf = {off, ans[8:1], msg_pkg::SYNC_CODE, msg_pkg::SYNC_LEN, msg_pkg::MSG_EXTENDED};
					lcnt = msg_pkg::SYNC_BYTES;
				end
			end
			msg_pkg::T_TAG: begin
				if (take) begin
					s_nxt.st = msg_pkg::T_IDLE;
					s_nxt.tag_valid = 1'b1;
					s_nxt.tag_type = s_r.tag_kind;
					s_nxt.tag_value = lnk.mo_data;
				end
			end
			msg_pkg::T_SEND: begin
				if (sent) begin
					if (s_r.idx + 3'h1 == s_r.cnt) begin
						s_nxt.st = msg_pkg::T_IDLE;
						s_nxt.mi_valid = 1'b0;
						s_nxt.mo_ready = 1'b1;
						s_nxt.bus_free = s_r.free_after;
					end else begin
						s_nxt.idx = s_r.idx + 3'h1;
						s_nxt.mi_data = s_r.txb[s_r.idx + 3'h1];
					end
				end
			end
			default: begin
				s_nxt.st = msg_pkg::T_IDLE;
			end
		endcase
		// A reject answers alone; bus free follows only when no nexus exists.
		if (reject) begin
			load = 1'b1;
			lbuf = {32'h00000000, msg_pkg::MSG_REJECT};
			lcnt = 3'h1;
			lfree = !nexus_valid;
		end
		if (drop) begin
			s_nxt.st = msg_pkg::T_IDLE;
			s_nxt.bus_free = 1'b1;
		end else if (load) begin
			s_nxt.st = msg_pkg::T_SEND;
			s_nxt.txb = lbuf;
			s_nxt.cnt = lcnt;
			s_nxt.idx = 3'h0;
			s_nxt.free_after = lfree;
			s_nxt.mi_valid = 1'b1;
			s_nxt.mi_data = lbuf[0];
			s_nxt.mo_ready = 1'b0;
		end
		// A bus hard reset drops everything back to asynchronous.
		if (lnk.bus_reset) begin
			s_nxt = '0;
			s_nxt.mo_ready = 1'b1;
		end
		s_nxt.period = s_r.agree[lnk.initiator_id][13:6];
		s_nxt.offset = {2'b00, s_r.agree[lnk.initiator_id][5:0]};
		s_nxt.sync = (s_r.agree[lnk.initiator_id][5:0] != 6'h00);
		s_nxt.period_ns = msg_pkg::period_ns(s_nxt.period);
	end

	// State register; power-on reset clears every agreement.
	always_ff @(posedge ref_clk) begin
		if (!reset_n) begin
			s_r <= '0;
			s_r.mo_ready <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign lnk.mo_ready = s_r.mo_ready;
	assign lnk.mi_valid = s_r.mi_valid;
	assign lnk.mi_data = s_r.mi_data;
	assign lnk.bus_free = s_r.bus_free;
	assign tx_taken = s_r.taken;
	assign rx_valid = s_r.rx_valid;
	assign rx_code = s_r.rx_code;
	assign tag_valid = s_r.tag_valid;
	assign tag_type = s_r.tag_type;
	assign tag_value = s_r.tag_value;
	assign device_reset = s_r.dev_reset;
	assign agreed_period = s_r.period;
	assign agreed_offset = s_r.offset;
	assign agreed_period_ns = s_r.period_ns;
	assign sync_mode = s_r.sync;

endmodule

// File: testbench/msg_link_sva.sv
// Checker that watches the byte-level message link between the target and initiator ends.
`timescale 1ns/1ps
module msg_link_sva (
	input wire logic ref_clk,
	input wire logic reset_n,
	input wire logic mo_valid,
	input wire logic [7:0] mo_data,
	input wire logic mo_atn,
	input wire logic mo_ready,
	input wire logic mi_valid,
	input wire logic [7:0] mi_data,
	input wire logic mi_ready,
	input wire logic bus_free,
	input wire logic bus_reset,
	input wire logic [3:0] initiator_id
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!reset_n);
	logic [2:0] ocnt_r;
	logic [2:0] icnt_r;
	wire ot = mo_valid && mo_ready;
	wire it = mi_valid && mi_ready;
	wire ofirst = ot && ocnt_r == 3'h0;
	wire ifirst = it && icnt_r == 3'h0;

	// Counts the bytes still owed by an extended message or a queue tag, so first bytes can be told apart.
	always_ff @(posedge ref_clk) begin
		if (!reset_n || bus_reset) begin
			ocnt_r <= 3'h0;
			icnt_r <= 3'h0;
		end else begin
			if (ot)
				ocnt_r <= ocnt_r != 3'h0 ? ocnt_r - 3'h1 : mo_data == 8'h01 ? 3'h4 : mo_data inside {[8'h20:8'h22]} ? 3'h1 : 3'h0;
			if (it)
				icnt_r <= icnt_r != 3'h0 ? icnt_r - 3'h1 : mi_data == 8'h01 ? 3'h4 : mi_data == 8'h20 ? 3'h1 : 3'h0;
		end
	end

	// The target opens only the messages it may send.
	in_codes_a: assert property (ifirst |-> mi_data inside {8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h0a, 8'h0b, 8'h20})
		else $error("target opened a message it may not send");
	sync_answer_a: assert property (ot && ocnt_r == 3'h2 ##1 ot |=> mi_valid && mi_data == 8'h01 && !mo_ready)
		else $error("sync request not answered at once");
	answer_hdr_a: assert property (it && icnt_r inside {3'h3, 3'h4} |-> mi_data == (icnt_r == 3'h4 ? 8'h03 : 8'h01))
		else $error("sync answer header wrong");
	period_range_a: assert property (it && icnt_r == 3'h2 |-> mi_data inside {[8'h0a:8'h6a]})
		else $error("answered period factor out of range");
	offset_range_a: assert property (it && icnt_r == 3'h2 ##1 it |-> mi_data <= 8'h3f)
		else $error("answered offset above ceiling");
	atn_final_a: assert property (ot && ocnt_r == 3'h1 |-> !mo_atn)
		else $error("attention still high on final byte");
	atn_more_a: assert property (ot && (ocnt_r > 3'h1 || ocnt_r == 3'h0 && mo_data == 8'h01) |-> mo_atn)
		else $error("attention low inside an extended message");
	reject_a: assert property (ofirst && !mo_atn && mo_data inside {[8'h0f:8'h1f], [8'h23:8'h7f], 8'h00, 8'h02, 8'h03, 8'h04,
		8'h0a, 8'h0b} |=> mi_valid && mi_data == 8'h07)
		else $error("unsupported message not rejected");
	report_quiet_a: assert property (ofirst && mo_data inside {8'h05, 8'h06, 8'h08, 8'h09, 8'h0d, 8'h0e} |=> !mi_valid)
		else $error("accepted message drew an answer");
	done_free_a: assert property (ifirst && mi_data == 8'h00 |=> bus_free)
		else $error("no bus free after command complete");
	reset_free_a: assert property (ofirst && mo_data == 8'h0c |=> bus_free)
		else $error("no bus free after device reset message");
	free_pulse_a: assert property (bus_free |=> !bus_free)
		else $error("bus free longer than one cycle");

	// Main scenarios reached on this link.
	cover property (ot && ocnt_r == 3'h2 ##1 ot ##1 mi_valid);
	cover property (ifirst && mi_data == 8'h07);
	cover property (bus_free);
endmodule

// File: testbench/testbench.sv
// Bench joining both link ends, plus a spare target driven directly to break the link rules.
`timescale 1ns/1ps
module testbench;
	logic ref_clk = 1'b0;
	logic reset_n = 1'b0;
	logic lvd = 1'b1;
	logic nexus = 1'b1;
	logic clr = 1'b0;
	logic [5:0] rq = 6'h00;
	logic [3:0] my_id = 4'h0;
	logic [7:0] tx_code = 8'h00, tx_tag = 8'h00, s_per = 8'h00, s_off = 8'h00, g_type = 8'h20, g_val = 8'h00;
	logic [7:0] m_code = 8'h00, seen = 8'h00, lrx = 8'h00, lin = 8'h00;
	logic tx_taken, rx_valid, tag_valid, dev_rst, t_sync, req_taken, refused, neg_done, need_neg, i_sync, in_valid, bf_seen;
	logic [7:0] rx_code, t_type, t_val, t_per, t_off, i_per, i_off, in_code, in_tag;
	logic [10:0] t_ns, i_ns;
	logic [7:0] pt [9] = '{8'h00, 8'h09, 8'h0a, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h6a, 8'h6b};
	logic [7:0] po [9] = '{8'h08, 8'h01, 8'h00, 8'h3f, 8'h40, 8'h08, 8'h10, 8'h3f, 8'hff};
	logic [7:0] ic [6] = '{8'h02, 8'h03, 8'h04, 8'h0a, 8'h0b, 8'h00};
	logic [7:0] oc [7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0d, 8'h0e};
	int n_fail = 0;
	int total_checks = 0;
	msg_link_if lnk();
	msg_link_if lnk2();

	msg_target msg_target_inst (.ref_clk(ref_clk), .reset_n(reset_n), .lnk(lnk), .lvd_mode(lvd), .nexus_valid(nexus),
		.tx_req(rq[4]), .tx_code(tx_code), .tx_tag_req(rq[5]), .tx_tag(tx_tag), .tx_taken(tx_taken), .rx_valid(rx_valid),
		.rx_code(rx_code), .tag_valid(tag_valid), .tag_type(t_type), .tag_value(t_val), .device_reset(dev_rst),
		.agreed_period(t_per), .agreed_offset(t_off), .agreed_period_ns(t_ns), .sync_mode(t_sync));
	msg_target msg_target_inst2 (.ref_clk(ref_clk), .reset_n(reset_n), .lnk(lnk2), .lvd_mode(lvd), .nexus_valid(nexus),
		.tx_req(rq[4]), .tx_code(tx_code), .tx_tag_req(rq[5]), .tx_tag(tx_tag), .tx_taken(), .rx_valid(), .rx_code(),
		.tag_valid(), .tag_type(), .tag_value(), .device_reset(), .agreed_period(), .agreed_offset(),
		.agreed_period_ns(), .sync_mode());
	msg_initiator msg_initiator_inst (.ref_clk(ref_clk), .reset_n(reset_n), .lnk(lnk), .my_id(my_id),
		.hard_reset_req(rq[3]), .sdtr_req(rq[0]), .sdtr_period(s_per), .sdtr_offset(s_off), .tag_req(rq[1]),
		.tag_type(g_type), .tag_value(g_val), .msg_req(rq[2]), .msg_code(m_code), .req_taken(req_taken),
		.sdtr_refused(refused), .neg_done(neg_done), .need_negotiation(need_neg), .agreed_period(i_per),
		.agreed_offset(i_off), .agreed_period_ns(i_ns), .sync_mode(i_sync), .in_valid(in_valid), .in_code(in_code),
		.in_tag(in_tag), .bus_free_seen(bf_seen));
	msg_link_sva msg_link_sva_inst (.ref_clk(ref_clk), .reset_n(reset_n), .mo_valid(lnk.mo_valid), .mo_data(lnk.mo_data),
		.mo_atn(lnk.mo_atn), .mo_ready(lnk.mo_ready), .mi_valid(lnk.mi_valid), .mi_data(lnk.mi_data),
		.mi_ready(lnk.mi_ready), .bus_free(lnk.bus_free), .bus_reset(lnk.bus_reset), .initiator_id(lnk.initiator_id));

	// Clock at 40 MHz.
	always #12.5 ref_clk = ~ref_clk;

	// Gathers the pulses of one step so that a scenario can look at them once it has settled.
	always @(posedge ref_clk) begin
		seen <= (clr ? 8'h00 : seen) | {lnk2.bus_free, refused, neg_done, bf_seen, in_valid, dev_rst, tag_valid, rx_valid};
		if (rx_valid)
			lrx <= rx_code;
		if (in_valid)
			lin <= in_code;
	end

	task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic results;
		if (n_fail == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Raises one level request, holds it until it is taken, then lets the exchange run out.
	task automatic issue(input int k);
		int n;
		clr <= 1'b1;
		@(posedge ref_clk);
		clr <= 1'b0;
		rq[k] <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!(k > 3 ? tx_taken : req_taken) && n < 50);
		rq[k] <= 1'b0;
		chk("taken", 11'h001, {10'h000, n < 50});
		repeat (16) @(posedge ref_clk);
	endtask

	task automatic ident;
		m_code <= 8'h80;
		issue(2);
	endtask

	task automatic sync_case(input logic [7:0] p, input logic [7:0] o);
		logic as;
		logic [7:0] ep;
		logic [7:0] eo;
		logic [10:0] ens;
		s_per <= p;
		s_off <= o;
		issue(0);
		ep = p > 8'h6a ? 8'h6a : lvd && p <= 8'h0a ? 8'h0a : p <= 8'h0c ? 8'h0c : p;
		as = p > 8'h6a || p < (lvd ? 8'h0a : 8'h0c);
		eo = as ? 8'h00 : o > 8'h3f ? 8'h3f : o;
		ens = ep == 8'h0a ? 11'h019 : ({3'h0, ep} * 11'h004 + 11'h018) / 11'h019 * 11'h019;
		chk("neg_done", 11'h001, seen[5]);
		chk("i_per", ep, i_per);
		chk("t_per", ep, t_per);
		chk("i_off", eo, i_off);
		chk("t_off", eo, t_off);
		chk("i_sync", eo != 8'h00, i_sync);
		chk("t_sync", eo != 8'h00, t_sync);
		if (eo != 8'h00) begin
			chk("i_ns", ens, i_ns);
			chk("t_ns", ens, t_ns);
		end
	endtask

	// Drives one out byte on the spare link and waits for the edge that takes it.
	task automatic put2(input logic [7:0] b, input logic a);
		int n;
		lnk2.mo_data <= b;
		lnk2.mo_atn <= a;
		lnk2.mo_valid <= 1'b1;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (!lnk2.mo_ready && n < 50);
		chk("put2_taken", 11'h001, {10'h000, n < 50});
	endtask

	// Main sequence of scenarios.
	initial begin
		lnk2.mo_valid = 1'b0;
		lnk2.mo_data = 8'h00;
		lnk2.mo_atn = 1'b0;
		lnk2.mi_ready = 1'b1;
		lnk2.bus_reset = 1'b0;
		lnk2.initiator_id = 4'h0;
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		chk("need_neg", 11'h001, need_neg);
		chk("t_off_rst", 11'h000, t_off);
		s_per <= 8'h19;
		issue(0);
		chk("refused", 11'h001, seen[6]);
		ident();
		chk("identify", 8'h80, lrx);
		for (int m = 1; m >= 0; m--) begin
			lvd <= m[0];
			for (int j = 0; j < 9; j++)
				sync_case(pt[j], po[j]);
		end
		sync_case(8'h19, 8'h08);
		chk("need_neg_ok", 11'h000, need_neg);
		my_id <= 4'h3;
		repeat (4) @(posedge ref_clk);
		chk("t_off_id3", 11'h000, t_off);
		my_id <= 4'h0;
		repeat (4) @(posedge ref_clk);
		chk("t_off_id0", 8'h08, t_off);
		for (int j = 0; j < 6; j++) begin
			tx_code <= ic[j];
			issue(4);
			chk("in_code", ic[j], lin);
			chk("free_done", ic[j] == 8'h00, seen[4]);
		end
		tx_tag <= 8'h5a;
		issue(5);
		chk("in_tag_code", 8'h20, lin);
		chk("in_tag", 8'h5a, in_tag);
		for (int j = 0; j < 7; j++) begin
			m_code <= oc[j];
			issue(2);
			chk("rx_code", oc[j], lrx);
			chk("rx_valid", 11'h001, seen[0]);
			chk("free_report", 11'h000, seen[4]);
		end
		for (int j = 0; j < 3; j++) begin
			g_type <= 8'h20 + 8'(j);
			g_val <= 8'h40 + 8'(j);
			issue(1);
			chk("tag_type", 8'h20 + 8'(j), t_type);
			chk("tag_value", 8'h40 + 8'(j), t_val);
			chk("tag_valid", 11'h001, seen[1]);
		end
		m_code <= 8'h30;
		issue(2);
		chk("reject", 8'h07, lin);
		chk("free_nexus", 11'h000, seen[4]);
		nexus <= 1'b0;
		m_code <= 8'h02;
		issue(2);
		chk("reject_in", 11'h001, seen[3]);
		chk("free_no_nexus", 11'h001, seen[4]);
		nexus <= 1'b1;
		ident();
		sync_case(8'h19, 8'h08);
		m_code <= 8'h0c;
		issue(2);
		chk("dev_reset", 11'h001, seen[2]);
		chk("t_off_dr", 11'h000, t_off);
		chk("i_off_dr", 11'h000, i_off);
		ident();
		sync_case(8'h19, 8'h08);
		issue(3);
		chk("t_off_hr", 11'h000, t_off);
		chk("need_neg_hr", 11'h001, need_neg);
		clr <= 1'b1;
		put2(8'h01, 1'b1);
		clr <= 1'b0;
		put2(8'h03, 1'b1);
		put2(8'h01, 1'b0);
		lnk2.mo_valid <= 1'b0;
		repeat (4) @(posedge ref_clk);
		chk("atn_drop_free", 11'h001, seen[7]);
		results();
	end

	// Cuts a hang short.
	initial begin
		repeat (10000) @(posedge ref_clk);
		n_fail++;
		results();
	end
endmodule
